// File: design/pulse_cmd_pkg.sv
// Function
// - three selectable pulse interpretation modes
// - source select, differential path by default
// - differential path counts up to 2 MHz
// - single-ended path counts up to 1 MHz
// - pulse/direction: A pulses, B high adds
// - single-ended step counts on falling edge only
// - direction high positive, low negative
// - up_step_n falling edge increments count
// - down_step_n falling edge decrements count
// - B leads A positive, A leads B negative
// - count sign independent of downstream scaling
// - quadrature counts every edge, four per line
// - differential up/down: A up, B down
// - position count zero at reset, accumulates
package pulse_cmd_pkg;

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam int          POS_W        = 32;
  localparam int          SYNC_STAGES  = 2;
  localparam int          CLK_HZ       = 10_000_000;
  localparam int          DIFF_MAX_HZ  = 2_000_000;
  localparam int          SE_MAX_HZ    = 1_000_000;
  // cycles per input period at the top rate, rounded down
  localparam int          DIFF_PER_CYC = CLK_HZ / DIFF_MAX_HZ;
  localparam int          SE_PER_CYC   = CLK_HZ / SE_MAX_HZ;
  localparam logic [31:0] POS_RESET    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_PULSE_DIR = 2'h0,
    MODE_UP_DOWN   = 2'h1,
    MODE_QUAD      = 2'h2
  } interp_mode_t;

  typedef enum logic {
    SRC_DIFF   = 1'h0,
    SRC_SINGLE = 1'h1
  } pulse_src_t;

  typedef struct packed {
    interp_mode_t mode;
    pulse_src_t   src;
  } pulse_cfg_t;

  typedef struct packed {
    logic a;
    logic b;
  } chan_pair_t;

endpackage : pulse_cmd_pkg

// File: design/pulse_command_decoder.sv
`timescale 1ns/1ps
module pulse_command_decoder
  import pulse_cmd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire pulse_cfg_t        cfg,
  input  wire chan_pair_t        diff_in,
  input  wire chan_pair_t        se_in,
  output logic                   count_up,
  output logic                   count_down,
  output logic signed [POS_W-1:0] pos_count
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_STAGES-1:0] diff_a_sync_reg, diff_b_sync_reg;
  logic [SYNC_STAGES-1:0] se_a_sync_reg, se_b_sync_reg;

  // both paths kept live so a source switch sees settled levels
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      diff_a_sync_reg <= '0;
      diff_b_sync_reg <= '0;
      se_a_sync_reg   <= '1; // pulled-up idle level
      se_b_sync_reg   <= '1;
    end else begin
      diff_a_sync_reg <= {diff_a_sync_reg[SYNC_STAGES-2:0], diff_in.a};
      diff_b_sync_reg <= {diff_b_sync_reg[SYNC_STAGES-2:0], diff_in.b};
      se_a_sync_reg   <= {se_a_sync_reg[SYNC_STAGES-2:0], se_in.a};
      se_b_sync_reg   <= {se_b_sync_reg[SYNC_STAGES-2:0], se_in.b};
    end
  end

  // ----------------------------------------------------------------
  // path select and edge history
  // ----------------------------------------------------------------
  logic a_now, b_now, a_prev, b_prev, single;
  logic diff_a_reg, diff_b_reg, se_a_reg, se_b_reg;

  // only last stages feed the mux; first stages stay private
  assign single = (cfg.src == SRC_SINGLE);
  assign a_now  = single ? se_a_sync_reg[SYNC_STAGES-1] : diff_a_sync_reg[SYNC_STAGES-1];
  assign b_now  = single ? se_b_sync_reg[SYNC_STAGES-1] : diff_b_sync_reg[SYNC_STAGES-1];

  // one history per path, reset to that path's idle level, so neither
  // reset nor a source switch fakes an edge; 10 MHz covers 2 MHz edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      diff_a_reg <= 1'b0;
      diff_b_reg <= 1'b0;
      se_a_reg   <= 1'b1; // pulled-up idle level
      se_b_reg   <= 1'b1;
    end else begin
      diff_a_reg <= diff_a_sync_reg[SYNC_STAGES-1];
      diff_b_reg <= diff_b_sync_reg[SYNC_STAGES-1];
      se_a_reg   <= se_a_sync_reg[SYNC_STAGES-1];
      se_b_reg   <= se_b_sync_reg[SYNC_STAGES-1];
    end
  end

  // previous sample of whichever path is selected
  assign a_prev = single ? se_a_reg : diff_a_reg;
  assign b_prev = single ? se_b_reg : diff_b_reg;

  // ----------------------------------------------------------------
  // interpretation decode
  // ----------------------------------------------------------------
  logic a_rise, a_fall, b_rise, b_fall, a_chg, b_chg;
  logic up_next, down_next;

  assign a_rise = a_now & ~a_prev;
  assign a_fall = ~a_now & a_prev;
  assign b_rise = b_now & ~b_prev;
  assign b_fall = ~b_now & b_prev;
  assign a_chg  = a_rise | a_fall;
  assign b_chg  = b_rise | b_fall;

  // the pulse edge is the rising one on the differential pulse line,
  // the falling one on the active-low single-ended inputs
  always_comb begin
    up_next   = 1'b0;
    down_next = 1'b0;
    unique case (cfg.mode)
      MODE_PULSE_DIR: begin
        if (single ? a_fall : a_rise) begin
          up_next   = b_now;
          down_next = ~b_now;
        end
      end
      MODE_UP_DOWN: begin
        up_next   = single ? a_fall : a_rise;
        down_next = single ? b_fall : b_rise;
      end
      MODE_QUAD: begin
        // B leads A: A moves to match B; A leads B: B moves to match A
        if (a_chg && !b_chg) begin
          up_next   = (a_now == b_now);
          down_next = (a_now != b_now);
        end else if (b_chg && !a_chg) begin
          up_next   = (a_now != b_now);
          down_next = (a_now == b_now);
        end
        // both changed at once is an illegal step, ignored
      end
      default: begin
        up_next   = 1'b0;
        down_next = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // position accumulator
  // ----------------------------------------------------------------
  logic signed [POS_W-1:0] pos_reg;
  logic                    up_reg, down_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pos_reg  <= POS_RESET;
      up_reg   <= 1'b0;
      down_reg <= 1'b0;
    end else begin
      up_reg   <= up_next;
      down_reg <= down_next;
      if (up_next && !down_next)
        pos_reg <= pos_reg + POS_W'(1);
      else if (down_next && !up_next)
        pos_reg <= pos_reg - POS_W'(1);
    end
  end

  assign pos_count  = pos_reg;
  assign count_up   = up_reg;
  assign count_down = down_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // single-ended step seen on its falling, active edge
  sequence s_se_step_fall;
    single && cfg.mode == MODE_PULSE_DIR && a_prev && !a_now;
  endsequence

  // differential step with direction high
  sequence s_diff_step_up;
    !single && cfg.mode == MODE_PULSE_DIR && a_rise && b_now;
  endsequence

  // lone b move ending with a and b apart: b has led
  sequence s_quad_b_first;
    cfg.mode == MODE_QUAD && b_chg && !a_chg && a_now != b_now;
  endsequence

  // lone a move ending with a and b apart: a has led
  sequence s_quad_a_first;
    cfg.mode == MODE_QUAD && a_chg && !b_chg && a_now != b_now;
  endsequence

  a_up_moves_pos: assert property (@(posedge clk) disable iff (!rstn)
    up_next && !down_next |=> pos_reg == $past(pos_reg) + POS_W'(1))
    else $error("count did not rise by one");
  a_down_moves_pos: assert property (@(posedge clk) disable iff (!rstn)
    down_next && !up_next |=> pos_reg == $past(pos_reg) - POS_W'(1))
    else $error("count did not fall by one");
  a_idle_holds_pos: assert property (@(posedge clk) disable iff (!rstn)
    !up_next && !down_next |=> $stable(pos_reg))
    else $error("count moved without an edge");
  a_se_step_dir: assert property (@(posedge clk) disable iff (!rstn)
    s_se_step_fall |-> (up_next == b_now) && (down_next == !b_now))
    else $error("step direction wrong");
  a_se_rise_quiet: assert property (@(posedge clk) disable iff (!rstn)
    single && cfg.mode != MODE_QUAD && a_rise && !b_chg |-> !up_next && !down_next)
    else $error("rising step counted");
  a_diff_dir_pulse: assert property (@(posedge clk) disable iff (!rstn)
    !single && cfg.mode == MODE_PULSE_DIR && a_rise |-> up_next == b_now)
    else $error("direction sign wrong");
  a_updown_chan: assert property (@(posedge clk) disable iff (!rstn)
    cfg.mode == MODE_UP_DOWN && !single |-> up_next == a_rise && down_next == b_rise)
    else $error("up/down channel mapping wrong");
  a_quad_every_edge: assert property (@(posedge clk) disable iff (!rstn)
    cfg.mode == MODE_QUAD && (a_chg ^ b_chg) |-> up_next ^ down_next)
    else $error("quadrature edge missed");
  a_quad_b_leads: assert property (@(posedge clk) disable iff (!rstn)
    cfg.mode == MODE_QUAD && a_chg && !b_chg && a_now == b_now |=> count_up)
    else $error("b-leads step not positive");
  a_sync_delay: assert property (@(posedge clk) disable iff (!rstn)
    !single |-> ##2 diff_a_sync_reg[SYNC_STAGES-1] == $past(diff_in.a, 2))
    else $error("synchroniser depth wrong");
  a_se_sync_delay: assert property (@(posedge clk) disable iff (!rstn)
    single |-> ##2 se_b_sync_reg[SYNC_STAGES-1] == $past(se_in.b, 2))
    else $error("single-ended synchroniser depth wrong");

  // quadrature sign follows whichever channel moved first
  a_quad_b_first: assert property (@(posedge clk) disable iff (!rstn)
    s_quad_b_first |=> count_up && !count_down)
    else $error("b-first step not positive");
  a_quad_a_first: assert property (@(posedge clk) disable iff (!rstn)
    s_quad_a_first |=> count_down && !count_up)
    else $error("a-first step not negative");
  a_quad_both_drop: assert property (@(posedge clk) disable iff (!rstn)
    cfg.mode == MODE_QUAD && a_chg && b_chg |-> !up_next && !down_next)
    else $error("double quadrature step counted");

  // a counted step reaches outputs and count one cycle on
  a_diff_step_up: assert property (@(posedge clk) disable iff (!rstn)
    s_diff_step_up |=> count_up && pos_reg == $past(pos_reg) + POS_W'(1))
    else $error("direction-high step not counted up");
  a_se_down_step: assert property (@(posedge clk) disable iff (!rstn)
    single && cfg.mode == MODE_UP_DOWN && b_fall && !a_fall |-> down_next && !up_next)
    else $error("single-ended down step missed");
  a_cancel_holds: assert property (@(posedge clk) disable iff (!rstn)
    up_next && down_next |=> $stable(pos_reg))
    else $error("cancelled steps moved the count");
  a_spare_mode_quiet: assert property (@(posedge clk) disable iff (!rstn)
    cfg.mode == 2'h3 |-> !up_next && !down_next)
    else $error("unused mode counted");
  a_outs_follow: assert property (@(posedge clk) disable iff (!rstn)
    1'b1 |=> count_up == $past(up_next) && count_down == $past(down_next))
    else $error("count pulses out of step");

endmodule : pulse_command_decoder

// File: dv/pulse_source_model.sv
`timescale 1ns/1ps
module pulse_source_model
  import pulse_cmd_pkg::*;
(
  input  wire logic clk,
  output chan_pair_t diff_o,
  output chan_pair_t se_o
);
  // idle: differential lines low, single-ended lines held up by the pull-ups
  initial begin
    diff_o = 2'h0;
    se_o   = 2'h3;
  end

  // wait whole cycles, then step just past the edge
  task automatic hold(input int h);
    repeat (h) @(posedge clk);
    #1;
  endtask : hold

  task automatic put(input logic se, input logic ch, input logic v);
    if (se) begin
      if (ch) se_o.b = v; else se_o.a = v;
    end else begin
      if (ch) diff_o.b = v; else diff_o.a = v;
    end
  endtask : put

  // active level is high on the differential path, low single-ended
  task automatic pulse(input logic se, input logic ch, input int n, input int h);
    for (int i = 0; i < n; i++) begin
      put(se, ch, ~se);
      hold(h);
      put(se, ch, se);
      hold(h);
    end
  endtask : pulse

  // direction settles well before the next step edge
  task automatic dir(input logic se, input logic v);
    put(se, 1'h1, v);
    hold(4);
  endtask : dir

  // one line cycle from idle: fwd has B leading A
  task automatic quad(input logic se, input int n, input logic fwd, input int h);
    for (int i = 0; i < n; i++) begin
      put(se, fwd, ~se);
      hold(h);
      put(se, ~fwd, ~se);
      hold(h);
      put(se, fwd, se);
      hold(h);
      put(se, ~fwd, se);
      hold(h);
    end
  endtask : quad

  // both channels move in one step, one whole-word write each way
  task automatic pair(input logic se, input int h);
    if (se) se_o = 2'h0; else diff_o = 2'h3;
    hold(h);
    if (se) se_o = 2'h3; else diff_o = 2'h0;
    hold(h);
  endtask : pair
endmodule : pulse_source_model

// File: dv/pulse_command_decoder_tb_top.sv
`timescale 1ns/1ps
module pulse_command_decoder_tb_top;
  import pulse_cmd_pkg::*;
  logic                    clk;
  logic                    rstn;
  pulse_cfg_t              cfg;
  chan_pair_t              diff_in;
  chan_pair_t              se_in;
  logic                    count_up;
  logic                    count_down;
  logic signed [POS_W-1:0] pos_count;
  int error_cnt = 0, checks = 0, cyc = 0, ups = 0, downs = 0, bu, bd;
  logic [POS_W-1:0] base;

  pulse_command_decoder dut (.clk(clk), .rstn(rstn), .cfg(cfg), .diff_in(diff_in),
    .se_in(se_in), .count_up(count_up), .count_down(count_down), .pos_count(pos_count));
  pulse_source_model src (.clk(clk), .diff_o(diff_in), .se_o(se_in));

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  // tally the one-cycle pulses; a hang cuts the run short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ups <= ups + int'(count_up === 1'h1);
    downs <= downs + int'(count_down === 1'h1);
    if (cyc == 5000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic cmp(input logic [POS_W-1:0] got, input logic [POS_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // a mode change fakes no edge, but a step in flight may still land, so judge from a settled baseline
  task automatic setup(input interp_mode_t m, input pulse_src_t s);
    @(posedge clk) #1 cfg = '{mode: m, src: s};
    repeat (8) @(posedge clk);
    #1;
    base = pos_count;
    bu = ups;
    bd = downs;
  endtask : setup

  task automatic expect_delta(input int d, input int nu, input int nd);
    repeat (6) @(posedge clk);
    #1;
    cmp(pos_count, base + d);
    cmp(32'(ups - bu), 32'(nu));
    cmp(32'(downs - bd), 32'(nd));
  endtask : expect_delta

  task automatic t_pulse_dir;
    setup(MODE_PULSE_DIR, SRC_DIFF);
    src.dir(1'h0, 1'h1);
    src.pulse(1'h0, 1'h0, 3, 3);
    src.dir(1'h0, 1'h0);
    src.pulse(1'h0, 1'h0, 2, 3);
    expect_delta(1, 3, 2);
    setup(MODE_PULSE_DIR, SRC_SINGLE);
    src.dir(1'h1, 1'h0);
    src.pulse(1'h1, 1'h0, 2, 5);
    src.dir(1'h1, 1'h1);
    src.pulse(1'h1, 1'h0, 4, 5);
    expect_delta(2, 4, 2);
    src.pulse(1'h0, 1'h0, 3, 3);
    expect_delta(2, 4, 2);
    $display("test pulse_dir done");
  endtask : t_pulse_dir

  task automatic t_up_down;
    setup(MODE_UP_DOWN, SRC_DIFF);
    src.pulse(1'h0, 1'h0, 3, 3);
    src.pulse(1'h0, 1'h1, 5, 3);
    src.pair(1'h0, 3);
    expect_delta(-2, 4, 6);
    setup(MODE_UP_DOWN, SRC_SINGLE);
    src.pulse(1'h1, 1'h0, 2, 5);
    src.pulse(1'h1, 1'h1, 3, 5);
    expect_delta(-1, 2, 3);
    $display("test up_down done");
  endtask : t_up_down

  task automatic t_quad;
    setup(MODE_QUAD, SRC_DIFF);
    src.quad(1'h0, 2, 1'h1, 3);
    src.quad(1'h0, 1, 1'h0, 3);
    src.pair(1'h0, 3);
    expect_delta(4, 8, 4);
    setup(MODE_QUAD, SRC_SINGLE);
    src.quad(1'h1, 1, 1'h0, 5);
    src.quad(1'h1, 2, 1'h1, 5);
    expect_delta(4, 8, 4);
    setup(interp_mode_t'(2'h3), SRC_DIFF);
    src.pulse(1'h0, 1'h0, 2, 3);
    src.pulse(1'h0, 1'h1, 2, 3);
    expect_delta(0, 0, 0);
    $display("test quad done");
  endtask : t_quad

  // step latency through the synchroniser, then a reset in mid-run
  task automatic t_reset;
    setup(MODE_PULSE_DIR, SRC_DIFF);
    src.dir(1'h0, 1'h1);
    src.put(1'h0, 1'h0, 1'h1);
    repeat (2) @(posedge clk);
    #1 cmp(32'(count_up), 32'h0);
    @(posedge clk) #1 cmp(32'(count_up), 32'h1);
    @(posedge clk) #1 cmp(32'(count_up), 32'h0);
    src.put(1'h0, 1'h0, 1'h0);
    rstn = 1'h0;
    #1 cmp(pos_count, 32'h0);
    cmp(32'({count_up, count_down}), 32'h0);
    repeat (2) @(posedge clk);
    #1 rstn = 1'h1;
    setup(MODE_PULSE_DIR, SRC_DIFF);
    src.pulse(1'h0, 1'h0, 2, 3);
    expect_delta(2, 2, 0);
    $display("test reset done");
  endtask : t_reset

  task automatic close_out;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  initial begin
    rstn = 1'h0;
    cfg = '{mode: MODE_PULSE_DIR, src: SRC_DIFF};
    repeat (8) @(posedge clk);
    #1 rstn = 1'h1;
    cmp(pos_count, 32'h0000_0000);
    t_pulse_dir();
    t_up_down();
    t_quad();
    t_reset();
    close_out();
  end
endmodule : pulse_command_decoder_tb_top
